// file: design/mci_pkg.sv
// Package: register map, field positions and reset values for the
// per-channel interrupt status and mask block.
// Assumes a 32-bit APB slave with one aligned word per register.
package mci_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int unsigned MCI_NCHAN  = 8;
  localparam int unsigned MCI_AW     = 8;
  localparam int unsigned MCI_DW     = 32;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] MCI_OFF_TX_RAW      = 8'h00;
  localparam logic [7:0] MCI_OFF_TX_MASKED   = 8'h04;
  localparam logic [7:0] MCI_OFF_TX_MSET     = 8'h08;
  localparam logic [7:0] MCI_OFF_TX_MCLR     = 8'h0c;
  localparam logic [7:0] MCI_OFF_VECTOR      = 8'h10;
  localparam logic [7:0] MCI_OFF_RX_RAW      = 8'h14;
  localparam logic [7:0] MCI_OFF_RX_MASKED   = 8'h18;
  localparam logic [7:0] MCI_OFF_RX_MSET     = 8'h1c;
  localparam logic [7:0] MCI_OFF_RX_MCLR     = 8'h20;
  localparam logic [7:0] MCI_OFF_EVT_STATUS  = 8'h24;
  localparam logic [7:0] MCI_OFF_EVT_MASK    = 8'h28;

  // ************************************************************
  // Combined vector field positions
  // ************************************************************
  localparam int unsigned MCI_VEC_TX_LSB     = 0;
  localparam int unsigned MCI_VEC_RX_LSB     = 8;
  localparam int unsigned MCI_VEC_STAT_BIT   = 16;
  localparam int unsigned MCI_VEC_HOST_BIT   = 17;
  localparam int unsigned MCI_VEC_LINK_BIT   = 30;
  localparam int unsigned MCI_VEC_USER_BIT   = 31;

  // ************************************************************
  // Event status bits (sticky)
  // ************************************************************
  localparam int unsigned MCI_EVT_TX_BIT     = 0;
  localparam int unsigned MCI_EVT_RX_BIT     = 1;
  localparam int unsigned MCI_EVT_MAC_BIT    = 2;
  localparam int unsigned MCI_EVT_MGMT_BIT   = 3;
  localparam int unsigned MCI_EVT_W          = 4;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0]  MCI_MASK_RST       = 8'h00;
  localparam logic [31:0] MCI_VEC_RST        = 32'h0000_0000;
  localparam logic [3:0]  MCI_EVT_RST        = 4'h0;

endpackage

// file: design/mci_mask_bank.sv
// Module: one eight-channel mask with write-one-to-set and
// write-one-to-clear ports, plus its masked view.
// Assumes the write strobes are one-cycle pulses in the bus clock.
`timescale 1ns/10ps
module mci_mask_bank (
  input  wire logic                         i_clk,
  input  wire logic                         i_sys_rst,
  input  wire logic                         i_set_we,
  input  wire logic                         i_clr_we,
  input  wire logic [mci_pkg::MCI_NCHAN-1:0] i_wdata,
  input  wire logic [mci_pkg::MCI_NCHAN-1:0] i_raw,
  output logic      [mci_pkg::MCI_NCHAN-1:0] o_mask,
  output logic      [mci_pkg::MCI_NCHAN-1:0] o_masked
);
  import mci_pkg::*;

  // ************************************************************
  // Per-channel mask state
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < MCI_NCHAN; g++) begin : g_chan
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          o_mask[g] <= MCI_MASK_RST[g];
        end else if (i_set_we && i_wdata[g]) begin
          o_mask[g] <= 1'b1;
        end else if (i_clr_we && i_wdata[g]) begin
          o_mask[g] <= 1'b0;
        end
      end
      assign o_masked[g] = i_raw[g] & o_mask[g];
    end
  endgenerate

endmodule

// file: design/mci_irq_regs.sv
// Module: APB register block for per-channel transmit and receive
// interrupt status, masks and the combined input vector.
// Assumes pending inputs are synchronous levels from the MAC core.
//
// Function
// - Transmit masked status bits 7..0 show masked pending; upper bits read zero.
// - Writing one to transmit mask set enables that channel; zeros do nothing.
// - Writing one to transmit mask clear disables that channel; zeros do nothing.
// - Vector bit 31 shows management user interrupt pending, resets to zero.
// - Vector bit 30 shows management link change pending, resets to zero.
// - Vector bit 17 shows host error pending.
// - Vector bit 16 shows statistics pending.
// - Vector bits 15..8 carry receive pending, bit 8 is channel 0.
// - Vector bits 7..0 carry transmit pending, bit 0 is channel 0.
// - Receive raw status bit n shows channel n pending before masking.
// - Receive masked status bit n shows channel n pending after masking.
// - Transmit raw status bits 7..0 show pending before masking; upper reserved.
// - Writing one to receive mask set enables that channel; zeros do nothing.
// - Writing one to receive mask clear disables that channel; zeros do nothing.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module mci_irq_regs (
  input  wire logic                          i_clk,
  input  wire logic                          i_sys_rst,
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [mci_pkg::MCI_AW-1:0]    i_paddr,
  input  wire logic [mci_pkg::MCI_DW-1:0]    i_pwdata,
  input  wire logic [mci_pkg::MCI_NCHAN-1:0] i_tx_channel_pending_vec,
  input  wire logic [mci_pkg::MCI_NCHAN-1:0] i_rx_channel_pending_vec,
  input  wire logic                          i_host_error_pending,
  input  wire logic                          i_statistics_pending,
  input  wire logic                          i_mgmt_user_irq_pending,
  input  wire logic                          i_mgmt_link_change_pending,
  output logic      [mci_pkg::MCI_DW-1:0]    o_prdata,
  output logic                               o_pready,
  output logic                               o_pslverr,
  output logic                               o_irq,
  output logic      [mci_pkg::MCI_DW-1:0]    o_combined_irq_vector
);
  import mci_pkg::*;

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic                 acc;
  logic                 wr;
  logic                 hit;
  logic                 tx_set_we;
  logic                 tx_clr_we;
  logic                 rx_set_we;
  logic                 rx_clr_we;
  logic                 evt_clr_we;
  logic                 evt_mask_we;
  logic [MCI_NCHAN-1:0] tx_mask;
  logic [MCI_NCHAN-1:0] rx_mask;
  logic [MCI_NCHAN-1:0] tx_masked;
  logic [MCI_NCHAN-1:0] rx_masked;
  logic [MCI_NCHAN-1:0] tx_raw;
  logic [MCI_NCHAN-1:0] rx_raw;
  logic                 host_q;
  logic                 stat_q;
  logic                 user_q;
  logic                 link_q;
  logic [MCI_EVT_W-1:0] evt_status;
  logic [MCI_EVT_W-1:0] evt_mask;
  logic [MCI_EVT_W-1:0] evt_now;
  logic [MCI_EVT_W-1:0] evt_prev;
  logic [MCI_EVT_W-1:0] evt_rise;
  logic [MCI_EVT_W-1:0] next_evt_status;
  logic [MCI_DW-1:0]    next_vector;
  logic [MCI_DW-1:0]    next_prdata;

  assign acc         = i_psel & i_penable;
  assign wr          = acc & i_pwrite & ~o_pready;
  assign tx_set_we   = wr && (i_paddr == MCI_OFF_TX_MSET);
  assign tx_clr_we   = wr && (i_paddr == MCI_OFF_TX_MCLR);
  assign rx_set_we   = wr && (i_paddr == MCI_OFF_RX_MSET);
  assign rx_clr_we   = wr && (i_paddr == MCI_OFF_RX_MCLR);
  assign evt_clr_we  = wr && (i_paddr == MCI_OFF_EVT_STATUS);
  assign evt_mask_we = wr && (i_paddr == MCI_OFF_EVT_MASK);

  always_comb begin
    case (i_paddr)
      MCI_OFF_TX_RAW, MCI_OFF_TX_MASKED, MCI_OFF_TX_MSET, MCI_OFF_TX_MCLR,
      MCI_OFF_VECTOR, MCI_OFF_RX_RAW, MCI_OFF_RX_MASKED, MCI_OFF_RX_MSET,
      MCI_OFF_RX_MCLR, MCI_OFF_EVT_STATUS, MCI_OFF_EVT_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // ************************************************************
  // Pending inputs, registered
  // ************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_raw <= MCI_MASK_RST;
      rx_raw <= MCI_MASK_RST;
      host_q <= 1'b0;
      stat_q <= 1'b0;
      user_q <= 1'b0;
      link_q <= 1'b0;
    end else begin
      tx_raw <= i_tx_channel_pending_vec;
      rx_raw <= i_rx_channel_pending_vec;
      host_q <= i_host_error_pending;
      stat_q <= i_statistics_pending;
      user_q <= i_mgmt_user_irq_pending;
      link_q <= i_mgmt_link_change_pending;
    end
  end

  // ************************************************************
  // Mask banks
  // ************************************************************
  mci_mask_bank u_tx_mask (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_set_we  (tx_set_we),
    .i_clr_we  (tx_clr_we),
    .i_wdata   (i_pwdata[MCI_NCHAN-1:0]),
    .i_raw     (tx_raw),
    .o_mask    (tx_mask),
    .o_masked  (tx_masked)
  );

  mci_mask_bank u_rx_mask (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_set_we  (rx_set_we),
    .i_clr_we  (rx_clr_we),
    .i_wdata   (i_pwdata[MCI_NCHAN-1:0]),
    .i_raw     (rx_raw),
    .o_mask    (rx_mask),
    .o_masked  (rx_masked)
  );

  // ************************************************************
  // Combined input vector
  // ************************************************************
  always_comb begin
    next_vector = MCI_VEC_RST;
    next_vector[MCI_VEC_TX_LSB +: MCI_NCHAN] = tx_masked;
    next_vector[MCI_VEC_RX_LSB +: MCI_NCHAN] = rx_masked;
    next_vector[MCI_VEC_STAT_BIT] = stat_q;
    next_vector[MCI_VEC_HOST_BIT] = host_q;
    next_vector[MCI_VEC_LINK_BIT] = link_q;
    next_vector[MCI_VEC_USER_BIT] = user_q;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_combined_irq_vector <= MCI_VEC_RST;
    end else begin
      o_combined_irq_vector <= next_vector;
    end
  end

  // ************************************************************
  // Sticky event status and mask
  // ************************************************************
  assign evt_now  = {user_q | link_q, host_q | stat_q, |rx_masked, |tx_masked};
  assign evt_rise = evt_now & ~evt_prev;

  always_comb begin
    next_evt_status = evt_status;
    if (evt_clr_we) begin
      next_evt_status = next_evt_status & ~i_pwdata[MCI_EVT_W-1:0];
    end
    next_evt_status = next_evt_status | evt_rise;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      evt_prev   <= MCI_EVT_RST;
      evt_status <= MCI_EVT_RST;
    end else begin
      evt_prev   <= evt_now;
      evt_status <= next_evt_status;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      evt_mask <= MCI_EVT_RST;
    end else if (evt_mask_we) begin
      evt_mask <= i_pwdata[MCI_EVT_W-1:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(next_evt_status & evt_mask);
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  always_comb begin
    next_prdata = '0;
    case (i_paddr)
      MCI_OFF_TX_RAW:     next_prdata[MCI_NCHAN-1:0] = tx_raw;
      MCI_OFF_TX_MASKED:  next_prdata[MCI_NCHAN-1:0] = tx_masked;
      MCI_OFF_TX_MSET:    next_prdata[MCI_NCHAN-1:0] = tx_mask;
      MCI_OFF_TX_MCLR:    next_prdata[MCI_NCHAN-1:0] = tx_mask;
      MCI_OFF_VECTOR:     next_prdata = o_combined_irq_vector;
      MCI_OFF_RX_RAW:     next_prdata[MCI_NCHAN-1:0] = rx_raw;
      MCI_OFF_RX_MASKED:  next_prdata[MCI_NCHAN-1:0] = rx_masked;
      MCI_OFF_RX_MSET:    next_prdata[MCI_NCHAN-1:0] = rx_mask;
      MCI_OFF_RX_MCLR:    next_prdata[MCI_NCHAN-1:0] = rx_mask;
      MCI_OFF_EVT_STATUS: next_prdata[MCI_EVT_W-1:0] = evt_status;
      MCI_OFF_EVT_MASK:   next_prdata[MCI_EVT_W-1:0] = evt_mask;
      default:            next_prdata = '0;
    endcase
  end

  // ************************************************************
  // APB answer: one wait state, ready pulses in access phase
  // ************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
    end else if (i_psel && i_penable && !o_pready) begin
      o_pready  <= 1'b1;
      o_pslverr <= ~hit;
      o_prdata  <= i_pwrite ? '0 : next_prdata;
    end else begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
    end
  end

endmodule

// file: dv/mci_irq_regs_asserts.sv
// Checker: port-level assertions for the interrupt register block.
// Assumes a bind onto mci_irq_regs, one clock, active-high reset.
`timescale 1ns/10ps
module mci_irq_regs_asserts (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [7:0]  i_tx_channel_pending_vec,
  input wire logic [7:0]  i_rx_channel_pending_vec,
  input wire logic        i_host_error_pending,
  input wire logic        i_statistics_pending,
  input wire logic        i_mgmt_user_irq_pending,
  input wire logic        i_mgmt_link_change_pending,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic [31:0] o_combined_irq_vector
);
  import mci_pkg::*;
  logic [1:0] up_cnt;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Cycles since reset release
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end
  // ************************************************************
  // Read access then answer
  // ************************************************************
  sequence s_rd(logic [7:0] a);
    i_psel && i_penable && !i_pwrite && !o_pready && i_paddr == a ##1 o_pready;
  endsequence
  property p_txm_hi; s_rd(MCI_OFF_TX_MASKED) |-> o_prdata[31:8] == 24'h0; endproperty
  property p_txr_hi; s_rd(MCI_OFF_TX_RAW) |-> o_prdata[31:8] == 24'h0; endproperty
  property p_rxr_hi; s_rd(MCI_OFF_RX_RAW) |-> o_prdata[31:8] == 24'h0; endproperty
  property p_rxm_hi; s_rd(MCI_OFF_RX_MASKED) |-> o_prdata[31:8] == 24'h0; endproperty
  property p_user;
    up_cnt == 2'h3 |-> o_combined_irq_vector[31] == $past(i_mgmt_user_irq_pending, 2);
  endproperty
  property p_link;
    up_cnt == 2'h3 |-> o_combined_irq_vector[30] == $past(i_mgmt_link_change_pending, 2);
  endproperty
  property p_host;
    up_cnt == 2'h3 |-> o_combined_irq_vector[17] == $past(i_host_error_pending, 2);
  endproperty
  property p_stat;
    up_cnt == 2'h3 |-> o_combined_irq_vector[16] == $past(i_statistics_pending, 2);
  endproperty
  property p_rx_vec;
    up_cnt == 2'h3 |->
      (o_combined_irq_vector[15:8] & ~$past(i_rx_channel_pending_vec, 2)) == 8'h0;
  endproperty
  property p_tx_vec;
    up_cnt == 2'h3 |->
      (o_combined_irq_vector[7:0] & ~$past(i_tx_channel_pending_vec, 2)) == 8'h0;
  endproperty
  a_txm_hi: assert property (p_txm_hi) else $error("tx masked upper bits set");
  a_txr_hi: assert property (p_txr_hi) else $error("tx raw upper bits set");
  a_rxr_hi: assert property (p_rxr_hi) else $error("rx raw upper bits set");
  a_rxm_hi: assert property (p_rxm_hi) else $error("rx masked upper bits set");
  a_user: assert property (p_user) else $error("vector user bit wrong");
  a_link: assert property (p_link) else $error("vector link bit wrong");
  a_host: assert property (p_host) else $error("vector host bit wrong");
  a_stat: assert property (p_stat) else $error("vector stat bit wrong");
  a_rx_vec: assert property (p_rx_vec) else $error("vector rx field wrong");
  a_tx_vec: assert property (p_tx_vec) else $error("vector tx field wrong");
endmodule
bind mci_irq_regs mci_irq_regs_asserts chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_tx_channel_pending_vec(i_tx_channel_pending_vec),
  .i_rx_channel_pending_vec(i_rx_channel_pending_vec),
  .i_host_error_pending(i_host_error_pending), .i_statistics_pending(i_statistics_pending),
  .i_mgmt_user_irq_pending(i_mgmt_user_irq_pending),
  .i_mgmt_link_change_pending(i_mgmt_link_change_pending), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_combined_irq_vector(o_combined_irq_vector));

// file: dv/mci_irq_regs_test.sv
// Testbench: APB master and pending sources for the interrupt registers.
// Assumes the package offsets; waits on ready with no fixed wait.
`timescale 1ns/10ps
module mci_irq_regs_test;
  import mci_pkg::*;
  logic        clk, rst, psel, penable, pwrite, host, stat, user, link, pready, pslverr, irq;
  logic [7:0]  paddr, tx, rx, mtx, mrx;
  logic [31:0] pwdata, prdata, vec, ws, wc, ve;
  logic [33:0] note;
  logic [33:0] exp_q[$];
  int          failures, check_count;
  mci_irq_regs dut_u (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_tx_channel_pending_vec(tx),
    .i_rx_channel_pending_vec(rx), .i_host_error_pending(host), .i_statistics_pending(stat),
    .i_mgmt_user_irq_pending(user), .i_mgmt_link_change_pending(link), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .o_combined_irq_vector(vec));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk_word(logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_bit(logic e, logic g);
    chk_word({31'h0, e}, {31'h0, g});
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ************************************************************
  // Bus master and answer monitor
  // ************************************************************
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic err, logic [31:0] e);
    exp_q.push_back({~wr, err, e});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, $urandom, 1'b0, e);
  endtask
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3ffffffff;
      chk_bit(note[32], pslverr);
      if (note[33]) chk_word(note[31:0], prdata);
    end
  end
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    final_report();
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {psel, penable, pwrite, host, stat, user, link} = 7'h0;
    {paddr, tx, rx, mtx, mrx, pwdata} = 72'h0;
    failures = 0;
    check_count = 0;
    rst = 1'b1;
    void'($urandom(32'h969e48c1));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(MCI_OFF_TX_MSET, 32'h0);
    rd(MCI_OFF_VECTOR, 32'h0);
    for (int i = 0; i < 8; i++) begin
      tx <= 8'($urandom);
      rx <= 8'($urandom);
      {host, stat, user, link} <= 4'($urandom);
      ws = $urandom;
      wc = $urandom;
      wr(MCI_OFF_TX_MSET, ws);
      mtx = mtx | ws[7:0];
      wr(MCI_OFF_TX_MCLR, wc);
      mtx = mtx & ~wc[7:0];
      rd(MCI_OFF_TX_MSET, {24'h0, mtx});
      rd(MCI_OFF_TX_MCLR, {24'h0, mtx});
      wr(MCI_OFF_TX_RAW, $urandom);
      rd(MCI_OFF_TX_RAW, {24'h0, tx});
      rd(MCI_OFF_TX_MASKED, {24'h0, tx & mtx});
      wr(MCI_OFF_RX_MSET, wc);
      mrx = mrx | wc[7:0];
      wr(MCI_OFF_RX_MCLR, ws);
      mrx = mrx & ~ws[7:0];
      rd(MCI_OFF_RX_RAW, {24'h0, rx});
      rd(MCI_OFF_RX_MASKED, {24'h0, rx & mrx});
      ve = {user, link, 12'h0, host, stat, rx & mrx, tx & mtx};
      wr(MCI_OFF_VECTOR, $urandom);
      rd(MCI_OFF_VECTOR, ve);
      chk_word(ve, vec);
    end
    apb(1'b0, 8'h40, 32'h0, 1'b1, 32'h0);
    apb(1'b1, 8'h44, $urandom, 1'b1, 32'h0);
    {host, stat, user, link, tx} <= 12'h0;
    wr(MCI_OFF_TX_MSET, 32'hff);
    wr(MCI_OFF_EVT_MASK, 32'h0);
    wr(MCI_OFF_EVT_STATUS, 32'hf);
    tx <= 8'h01;
    repeat (6) @(posedge clk);
    chk_bit(1'b0, irq);
    rd(MCI_OFF_EVT_STATUS, 32'h1);
    wr(MCI_OFF_EVT_MASK, 32'h1);
    repeat (3) @(posedge clk);
    chk_bit(1'b1, irq);
    wr(MCI_OFF_EVT_STATUS, 32'h1);
    host <= 1'b1;
    repeat (6) @(posedge clk);
    chk_bit(1'b0, irq);
    rd(MCI_OFF_EVT_STATUS, 32'h4);
    final_report();
  end
endmodule
